// File: rtl/interval_carrier_timer.sv
// Eight-bit compare timer with interval, PWM and infrared carrier operation.
//
// Contract
// R1: Run bit low stops and zeroes counter.
// R2: Clock select picks one of eight sources.
// R3: Mode field selects interval, carrier or PWM.
// R4: Default output level follows its control bit.
// R5: Output enable gives square wave in interval.
// R6: Software keeps mode bits while running.
// R7: Software rewrites compare one after restart.
// R8: Timer clock over six times companion's.
// R9: Carrier enable and next level shape output.
// R10: Read-only status flag shows output enablement.
// R11: Software keeps carrier enable while running.
// R12: Software clears port direction for output.
// R13: Compare zero match interrupts and clears counter.
// R14: Interval mode ignores compare register one.
// R15: Interrupt interval is N plus one ticks.
// R16: Counting starts within one count tick.
// R17: Match clears counter and inverts output.
// R18: Stopping returns interrupt and output to default.
// R19: Software uses compare zero 01H to FEH.
// R20: Compare zero changes only while stopped; the code also accepts compare zero writes while running.
// R21: Eight-bit counter increments on each tick.
`timescale 1ns/1ps
`default_nettype none

module interval_carrier_timer #(
   parameter int COUNT_WIDTH = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Register port.
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Clock source and companion counter.
   input wire logic low_speed_osc_clock,
   input wire logic companion_counter_irq,
   // Timer outputs.
   output logic timer_irq,
   output logic timer_output_pin,
   output logic timer_output_oe_n
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   interval_carrier_pkg::mode_control_t mode_reg;
   logic [7:0] port1_direction_reg;
   logic carrier_enable_reg;
   logic next_output_level_reg;
   logic carrier_status_flag_reg;
   logic [COUNT_WIDTH-1:0] compare_reg_0;
   logic [COUNT_WIDTH-1:0] compare_reg_1;
   logic [COUNT_WIDTH-1:0] count_reg;
   logic [COUNT_WIDTH-1:0] count_next;
   logic [interval_carrier_pkg::PRESCALE_WIDTH-1:0] prescale_reg;
   logic [interval_carrier_pkg::LSO_WIDTH-1:0] lso_count_reg;
   logic lso_prev_reg;
   logic companion_prev_reg;
   logic toggle_reg;
   logic toggle_next;
   logic phase_reg;
   logic phase_next;
   logic irq_reg;
   logic pin_reg;
   logic pin_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode.

   wire wr_mode = reg_wr_en && (reg_addr == interval_carrier_pkg::ADDR_TIMER1_MODE_CONTROL);
   wire wr_carrier = reg_wr_en && (reg_addr == interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL);
   wire wr_port = reg_wr_en && (reg_addr == interval_carrier_pkg::ADDR_PORT1_DIRECTION);
   wire wr_cmp0 = reg_wr_en && (reg_addr == interval_carrier_pkg::ADDR_COMPARE_REG_0);
   wire wr_cmp1 = reg_wr_en && (reg_addr == interval_carrier_pkg::ADDR_COMPARE_REG_1);
   wire [7:0] carrier_read = {5'h00, carrier_enable_reg, next_output_level_reg, carrier_status_flag_reg};

   always_comb begin
      unique case (reg_addr)
         interval_carrier_pkg::ADDR_TIMER1_MODE_CONTROL: rdata_next = mode_reg;
         interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL: rdata_next = carrier_read;
         interval_carrier_pkg::ADDR_PORT1_DIRECTION: rdata_next = port1_direction_reg;
         interval_carrier_pkg::ADDR_COMPARE_REG_0: rdata_next = 8'(compare_reg_0);
         interval_carrier_pkg::ADDR_COMPARE_REG_1: rdata_next = 8'(compare_reg_1);
         default: rdata_next = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count clock selection.

   function automatic logic low_bits_full(input logic [15:0] value, input int bits);
      logic [15:0] mask;
      mask = 16'((17'h00001 << bits) - 17'h00001);
      return (value & mask) == mask;
   endfunction

   wire lso_rise = low_speed_osc_clock && !lso_prev_reg;
   wire [15:0] prescale_ext = 16'(prescale_reg);
   wire [15:0] lso_ext = 16'(lso_count_reg);
   logic tick;

   always_comb begin
      unique case (mode_reg.clock_select)  // R2
         interval_carrier_pkg::CLK_PRS: tick = 1'b1;
         interval_carrier_pkg::CLK_PRS_DIV4: tick = low_bits_full(prescale_ext, interval_carrier_pkg::DIV_4_BITS);
         interval_carrier_pkg::CLK_PRS_DIV16: tick = low_bits_full(prescale_ext, interval_carrier_pkg::DIV_16_BITS);
         interval_carrier_pkg::CLK_PRS_DIV64: tick = low_bits_full(prescale_ext, interval_carrier_pkg::DIV_64_BITS);
         interval_carrier_pkg::CLK_PRS_DIV4096: tick = low_bits_full(prescale_ext,
            interval_carrier_pkg::DIV_4096_BITS);
         interval_carrier_pkg::CLK_LSO_DIV128: tick = lso_rise &&
            low_bits_full(lso_ext, interval_carrier_pkg::LSO_DIV_128_BITS);
         interval_carrier_pkg::CLK_LSO_DIV512: tick = lso_rise &&
            low_bits_full(lso_ext, interval_carrier_pkg::LSO_DIV_512_BITS);
         interval_carrier_pkg::CLK_LSO: tick = lso_rise;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter, compare and output toggling.

   wire run = mode_reg.run_enable;
   wire is_interval = mode_reg.mode_select == interval_carrier_pkg::MODE_INTERVAL;
   wire is_carrier = mode_reg.mode_select == interval_carrier_pkg::MODE_CARRIER;
   wire is_pwm = mode_reg.mode_select == interval_carrier_pkg::MODE_PWM;
   wire match0 = count_reg == compare_reg_0;
   wire match1 = count_reg == compare_reg_1;
   wire [COUNT_WIDTH-1:0] count_inc = COUNT_WIDTH'(count_reg + COUNT_WIDTH'(interval_carrier_pkg::COUNT_STEP));
   // Interval mode looks only at compare zero; carrier and PWM alternate by phase.
   wire cmp0_hit = run && tick && match0 && (is_interval || !phase_reg);  // R14
   wire cmp1_hit = run && tick && match1 && (is_carrier || is_pwm) && phase_reg;
   wire clear_hit = cmp0_hit || (cmp1_hit && is_carrier);  // R15
   wire irq_hit = clear_hit;

   always_comb begin
      count_next = count_reg;
      toggle_next = toggle_reg;
      phase_next = phase_reg;
      if (!run) begin
         count_next = COUNT_WIDTH'(interval_carrier_pkg::COUNT_ZERO);  // R1
         toggle_next = 1'b0;  // R18
         phase_next = 1'b0;
      end else if (tick) begin  // R16
         if (clear_hit) begin
            count_next = COUNT_WIDTH'(interval_carrier_pkg::COUNT_ZERO);  // R13
         end else begin
            count_next = count_inc;  // R21
         end
         if (cmp0_hit || cmp1_hit) begin
            toggle_next = !toggle_reg;  // R17
            phase_next = is_interval ? 1'b0 : !phase_reg;  // R3
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Carrier output control and pin level.

   wire companion_rise = companion_counter_irq && !companion_prev_reg;
   wire carrier_level = carrier_status_flag_reg && (carrier_enable_reg ? phase_reg : 1'b1);  // R9
   wire square_level = mode_reg.default_output_level ^ toggle_reg;  // R4

   always_comb begin
      if (!mode_reg.output_enable || !run) begin
         pin_next = mode_reg.default_output_level;  // R18
      end else if (is_carrier) begin
         pin_next = carrier_level;  // R9
      end else begin
         pin_next = square_level;  // R5
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State update.

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_reg <= interval_carrier_pkg::mode_control_t'(interval_carrier_pkg::RESET_MODE_CONTROL);
         port1_direction_reg <= interval_carrier_pkg::RESET_PORT1_DIRECTION;
         carrier_enable_reg <= 1'b0;
         next_output_level_reg <= 1'b0;
         carrier_status_flag_reg <= 1'b0;
         compare_reg_0 <= COUNT_WIDTH'(interval_carrier_pkg::RESET_COMPARE);
         compare_reg_1 <= COUNT_WIDTH'(interval_carrier_pkg::RESET_COMPARE);
         count_reg <= COUNT_WIDTH'(interval_carrier_pkg::COUNT_ZERO);
         prescale_reg <= '0;
         lso_count_reg <= '0;
         lso_prev_reg <= 1'b0;
         companion_prev_reg <= 1'b0;
         toggle_reg <= 1'b0;
         phase_reg <= 1'b0;
         irq_reg <= 1'b0;
         pin_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         if (wr_mode) begin
            mode_reg <= interval_carrier_pkg::mode_control_t'(reg_wdata);
         end
         if (wr_carrier) begin
            carrier_enable_reg <= reg_wdata[interval_carrier_pkg::CARRIER_ENABLE_BIT];
            next_output_level_reg <= reg_wdata[interval_carrier_pkg::NEXT_LEVEL_BIT];
         end
         if (companion_rise) begin
            carrier_status_flag_reg <= next_output_level_reg;  // R10
         end
         if (wr_port) begin
            port1_direction_reg <= reg_wdata;
         end
         if (wr_cmp0) begin
            compare_reg_0 <= COUNT_WIDTH'(reg_wdata);
         end
         if (wr_cmp1) begin
            compare_reg_1 <= COUNT_WIDTH'(reg_wdata);
         end
         count_reg <= count_next;
         prescale_reg <= prescale_reg + 1'b1;
         if (lso_rise) begin
            lso_count_reg <= lso_count_reg + 1'b1;
         end
         lso_prev_reg <= low_speed_osc_clock;
         companion_prev_reg <= companion_counter_irq;
         toggle_reg <= toggle_next;
         phase_reg <= phase_next;
         irq_reg <= irq_hit;  // R13
         pin_reg <= pin_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign timer_irq = irq_reg;
   assign timer_output_pin = pin_reg;
   assign timer_output_oe_n = port1_direction_reg[interval_carrier_pkg::TIMER_PIN_DIR_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   AST_R1: assert property (@(posedge clk) disable iff (!rst_n) !run |=> count_reg == '0) // R1
      else $error("Counter not zero while stopped.");

   AST_R2: assert property (@(posedge clk) disable iff (!rst_n) // R2
      (mode_reg.clock_select == interval_carrier_pkg::CLK_PRS) |-> tick)
      else $error("Undivided clock does not tick every cycle.");

   AST_R13: assert property (@(posedge clk) disable iff (!rst_n) // R13
      (run && tick && is_interval && match0) |=> (count_reg == '0) && timer_irq)
      else $error("Compare zero match did not clear and interrupt.");

   AST_R14: assert property (@(posedge clk) disable iff (!rst_n) // R14
      (run && tick && is_interval && match1 && !match0) |=> !timer_irq && (count_reg == $past(count_inc)))
      else $error("Interval mode reacted to compare one.");

   AST_R15: assert property (@(posedge clk) disable iff (!rst_n) // R15
      (run && tick && is_interval && match0) ##1 (run && is_interval && !wr_mode && !wr_cmp0)[*2]
      |-> !timer_irq)
      else $error("Interrupt repeated too early.");

   AST_R17: assert property (@(posedge clk) disable iff (!rst_n) // R17
      (run && tick && is_interval && match0) |=> toggle_reg != $past(toggle_reg))
      else $error("Output did not invert on match.");

   AST_R18: assert property (@(posedge clk) disable iff (!rst_n) // R18
      !run |=> !timer_irq && !toggle_reg && (timer_output_pin == $past(mode_reg.default_output_level)))
      else $error("Stop did not restore default levels.");

   AST_R21: assert property (@(posedge clk) disable iff (!rst_n) // R21
      (run && tick && !clear_hit) |=> count_reg == $past(count_inc))
      else $error("Counter did not increment on tick.");

   AST_R16: assert property (@(posedge clk) disable iff (!rst_n) // R16
      (run && tick && count_reg == '0 && !match0) |=> count_reg != '0)
      else $error("Counter did not start on first tick.");

   AST_R10: assert property (@(posedge clk) disable iff (!rst_n) // R10
      companion_rise |=> carrier_status_flag_reg == $past(next_output_level_reg))
      else $error("Status flag did not follow next level.");

   AST_R9: assert property (@(posedge clk) disable iff (!rst_n) // R9
      (run && is_carrier && mode_reg.output_enable && !carrier_status_flag_reg) |=> !timer_output_pin)
      else $error("Carrier output not low while disabled.");

   AST_R5: assert property (@(posedge clk) disable iff (!rst_n) // R5
      (run && is_interval && mode_reg.output_enable) |=> timer_output_pin == $past(square_level))
      else $error("Square wave level wrong.");

   AST_R4: assert property (@(posedge clk) disable iff (!rst_n) // R4
      !mode_reg.output_enable |=> timer_output_pin == $past(mode_reg.default_output_level))
      else $error("Disabled output not at default level.");

   AST_R3: assert property (@(posedge clk) disable iff (!rst_n) // R3
      (run && tick && is_pwm && phase_reg && match1) |=> !timer_irq && (count_reg == $past(count_inc)))
      else $error("Output mode compare one match cleared or interrupted.");

   AST_R3_CARRIER: assert property (@(posedge clk) disable iff (!rst_n) // R3
      (run && tick && is_carrier && phase_reg && match1) |=> (count_reg == '0) && timer_irq)
      else $error("Carrier compare one match did not clear and interrupt.");

endmodule

`default_nettype wire

// File: rtl/interval_carrier_pkg.sv
// Package with the register map, field layouts and timing constants of the interval and carrier timer.
package interval_carrier_pkg;

   // Register addresses on the 16-bit register port.
   localparam logic [15:0] ADDR_PORT1_DIRECTION = 16'hff21;
   localparam logic [15:0] ADDR_TIMER1_MODE_CONTROL = 16'hff6c;
   localparam logic [15:0] ADDR_CARRIER_OUTPUT_CONTROL = 16'hff6d;
   localparam logic [15:0] ADDR_COMPARE_REG_0 = 16'hff70;
   localparam logic [15:0] ADDR_COMPARE_REG_1 = 16'hff71;

   // Reset values and count step.
   localparam logic [7:0] RESET_PORT1_DIRECTION = 8'hff;
   localparam logic [7:0] RESET_MODE_CONTROL = 8'h00;
   localparam logic [7:0] RESET_COMPARE = 8'h00;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam logic [7:0] COUNT_STEP = 8'h01;

   // Carrier control register bit positions.
   localparam int CARRIER_ENABLE_BIT = 2;
   localparam int NEXT_LEVEL_BIT = 1;
   localparam int STATUS_FLAG_BIT = 0;

   // Port direction bit that steers the timer output pin.
   localparam int TIMER_PIN_DIR_BIT = 6;

   // Prescaler taps as powers of two.
   localparam int PRESCALE_WIDTH = 12;
   localparam int DIV_4_BITS = 2;
   localparam int DIV_16_BITS = 4;
   localparam int DIV_64_BITS = 6;
   localparam int DIV_4096_BITS = 12;
   localparam int LSO_WIDTH = 9;
   localparam int LSO_DIV_128_BITS = 7;
   localparam int LSO_DIV_512_BITS = 9;

   // Operating modes.
   typedef enum logic [1:0] {
      MODE_INTERVAL = 2'b00,
      MODE_CARRIER = 2'b01,
      MODE_PWM = 2'b10,
      MODE_PROHIBITED = 2'b11
   } timer_mode_t;

   // Count clock sources.
   typedef enum logic [2:0] {
      CLK_PRS = 3'b000,
      CLK_PRS_DIV4 = 3'b001,
      CLK_PRS_DIV16 = 3'b010,
      CLK_PRS_DIV64 = 3'b011,
      CLK_PRS_DIV4096 = 3'b100,
      CLK_LSO_DIV128 = 3'b101,
      CLK_LSO_DIV512 = 3'b110,
      CLK_LSO = 3'b111
   } clock_select_t;

   // Layout of the mode control register, bit 7 first.
   typedef struct packed {
      logic run_enable;
      clock_select_t clock_select;
      timer_mode_t mode_select;
      logic default_output_level;
      logic output_enable;
   } mode_control_t;

endpackage

// File: testbench/test_interval_carrier_timer.sv
// Self-checking testbench for the interval and carrier timer.
`timescale 1ns/1ps
`default_nettype none

module test_interval_carrier_timer;
   logic clk;
   logic rst_n;
   logic [15:0] reg_addr;
   logic reg_wr_en;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic low_speed_osc_clock;
   logic companion_counter_irq;
   logic timer_irq;
   logic timer_output_pin;
   logic timer_output_oe_n;
   logic [1:0] lso_cnt = 2'h0;
   logic [7:0] mode_now;
   int n_fail;
   int checks;

   interval_carrier_timer u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .low_speed_osc_clock(low_speed_osc_clock),
      .companion_counter_irq(companion_counter_irq), .timer_irq(timer_irq),
      .timer_output_pin(timer_output_pin), .timer_output_oe_n(timer_output_oe_n));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // The low-speed oscillator runs at a quarter of the system clock.
   always @(negedge clk) begin
      lso_cnt <= lso_cnt + 2'h1;
   end
   assign low_speed_osc_clock = lso_cnt[1];

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] addr, input logic [7:0] data);
      reg_addr = addr;
      reg_wdata = data;
      reg_wr_en = 1'b1;
      @(negedge clk);
      reg_wr_en = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [15:0] addr, output logic [7:0] data);
      reg_addr = addr;
      repeat (2) @(negedge clk);
      data = reg_rdata;
   endtask

   task automatic wait_irq(input int limit, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (timer_irq !== 1'b1 && n < limit);
   endtask

   // Fields are settled while stopped, then only the run bit is raised.
   task automatic start(input logic [7:0] mode);
      wr(interval_carrier_pkg::ADDR_TIMER1_MODE_CONTROL, mode);
      wr(interval_carrier_pkg::ADDR_TIMER1_MODE_CONTROL, mode | 8'h80);
      mode_now = mode | 8'h80;
   endtask

   task automatic stop_timer();
      mode_now = mode_now & 8'h7f;
      wr(interval_carrier_pkg::ADDR_TIMER1_MODE_CONTROL, mode_now);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      logic [7:0] d;
      rd(interval_carrier_pkg::ADDR_PORT1_DIRECTION, d);
      chk("port1_direction", d, 16'hff);
      rd(interval_carrier_pkg::ADDR_TIMER1_MODE_CONTROL, d);
      chk("timer1_mode_control", d, 16'h00);
      rd(interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL, d);
      chk("carrier_output_control", d, 16'h00);
      rd(interval_carrier_pkg::ADDR_COMPARE_REG_0, d);
      chk("compare_reg_0", d, 16'h00);
      rd(16'hff00, d);
      chk("unmapped", d, 16'h00);
      chk("oe_n_reset", timer_output_oe_n, 16'h1);
      chk("pin_reset", timer_output_pin, 16'h0);
      wr(interval_carrier_pkg::ADDR_PORT1_DIRECTION, 8'hbf);
      rd(interval_carrier_pkg::ADDR_PORT1_DIRECTION, d);
      chk("port1_direction_rw", d, 16'hbf);
      chk("oe_n_driven", timer_output_oe_n, 16'h0);
   endtask

   task automatic test_interval();
      int n;
      wr(interval_carrier_pkg::ADDR_COMPARE_REG_0, 8'h02);
      wr(interval_carrier_pkg::ADDR_COMPARE_REG_1, 8'h01);
      start(8'h01);
      for (int i = 0; i < 3; i++) begin
         wait_irq(20, n);
         chk("irq_spacing", n + 1, 16'h3);
         chk("pin_before_match", timer_output_pin, i[0]);
         @(negedge clk);
         chk("irq_pulse", timer_irq, 16'h0);
         chk("pin_toggled", timer_output_pin, !i[0]);
      end
      stop_timer();
      repeat (2) @(negedge clk);
      chk("pin_stopped", timer_output_pin, 16'h0);
      wait_irq(10, n);
      chk("no_irq_stopped", n, 16'ha);
      start(8'h01);
      wait_irq(20, n);
      chk("restart_from_zero", n, 16'h2);
      stop_timer();
   endtask

   task automatic test_default_level();
      int n;
      wr(interval_carrier_pkg::ADDR_TIMER1_MODE_CONTROL, 8'h03);
      mode_now = 8'h03;
      repeat (2) @(negedge clk);
      chk("default_high", timer_output_pin, 16'h1);
      start(8'h03);
      wait_irq(20, n);
      @(negedge clk);
      chk("toggle_from_high", timer_output_pin, 16'h0);
      stop_timer();
      repeat (2) @(negedge clk);
      chk("back_to_high", timer_output_pin, 16'h1);
      start(8'h02);
      wait_irq(20, n);
      repeat (2) @(negedge clk);
      chk("output_disabled", timer_output_pin, 16'h1);
      stop_timer();
   endtask

   task automatic test_clock_select();
      int per[8] = '{1, 4, 16, 64, 4096, 512, 2048, 4};
      int n;
      wr(interval_carrier_pkg::ADDR_COMPARE_REG_0, 8'h01);
      for (int c = 0; c < 8; c++) begin
         start({1'b0, c[2:0], 4'h0});
         wait_irq(6 * per[c] + 20, n);
         wait_irq(6 * per[c] + 20, n);
         chk("tick_period", n, 2 * per[c]);
         stop_timer();
      end
   endtask

   task automatic test_carrier();
      logic [7:0] d;
      int hi;
      wr(interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL, 8'hf9);
      rd(interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL, d);
      chk("carrier_ro_bits", d, 16'h00);
      wr(interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL, 8'h02);
      wr(interval_carrier_pkg::ADDR_COMPARE_REG_1, 8'h01);
      start(8'h05);
      repeat (3) @(negedge clk);
      chk("carrier_idle_low", timer_output_pin, 16'h0);
      companion_counter_irq = 1'b1;
      rd(interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL, d);
      @(negedge clk);
      chk("status_set", d, 16'h03);
      chk("level_high", timer_output_pin, 16'h1);
      companion_counter_irq = 1'b0;
      wr(interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL, 8'h00);
      repeat (8) @(negedge clk);
      companion_counter_irq = 1'b1;
      rd(interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL, d);
      @(negedge clk);
      chk("status_clear", d, 16'h00);
      chk("level_low", timer_output_pin, 16'h0);
      companion_counter_irq = 1'b0;
      stop_timer();
      wr(interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL, 8'h06);
      wr(interval_carrier_pkg::ADDR_COMPARE_REG_1, 8'h01);
      start(8'h05);
      companion_counter_irq = 1'b1;
      rd(interval_carrier_pkg::ADDR_CARRIER_OUTPUT_CONTROL, d);
      chk("status_carrier", d, 16'h07);
      hi = 0;
      for (int k = 0; k < 16; k++) begin
         @(negedge clk);
         hi += timer_output_pin;
      end
      chk("carrier_pulses", hi, 16'h8);
      stop_timer();
   endtask

   task automatic test_pwm();
      int n;
      wr(interval_carrier_pkg::ADDR_COMPARE_REG_0, 8'h03);
      wr(interval_carrier_pkg::ADDR_COMPARE_REG_1, 8'h01);
      start(8'h09);
      wait_irq(20, n);
      wait_irq(20, n);
      chk("pwm_period", n, 16'h4);
      stop_timer();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (n_fail == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      reg_addr = 16'h0000;
      reg_wr_en = 1'b0;
      reg_wdata = 8'h00;
      companion_counter_irq = 1'b0;
      mode_now = 8'h00;
      n_fail = 0;
      checks = 0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      test_reset();
      test_interval();
      test_default_level();
      test_clock_select();
      test_carrier();
      test_pwm();
      end_sim();
   end

   // The whole run needs fewer than 28000 cycles.
   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      end_sim();
   end
endmodule

`default_nettype wire
